// ===== rtl/sdo_sync_ctrl.sv
// Parameter-access abort coder, error reset and sync-status monitor
`timescale 1ns/1ps
module sdo_sync_ctrl (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic req_valid,
  input wire sdo_sync_pkg::req_faults_type req_faults,
  output logic req_ready,
  output logic resp_valid,
  output logic resp_abort,
  output sdo_sync_pkg::abort_code_type resp_code,
  input wire logic ctrl_word_valid,
  input wire logic [15:0] ctrl_word,
  input wire logic panel_stop,
  input wire logic ack_signal,
  input wire logic ack_input_hw,
  input wire logic error_set,
  output logic error_active,
  input wire logic sb_sync_tick,
  input wire logic sb_pdo_tick,
  input wire logic co_sync_tick,
  output logic task_tick,
  output logic sb_sync_ok,
  output logic co_sync_ok
);
  sdo_sync_pkg::srv_state_type state_r;
  sdo_sync_pkg::req_faults_type faults_r;
  sdo_sync_pkg::abort_code_type code_nxt;
  logic abort_nxt;
  logic [1:0] ctrl_src_r;
  logic [3:0] sb_mode_r;
  logic [9:0] shift_r;
  logic error_r;
  logic ack_sig_d_r;
  logic panel_d_r;
  logic [4:0] us_div_r;
  logic us_tick;
  logic [9:0] task_us_r;
  logic [9:0] sync_us;
  logic sb_event;
  logic [15:0] period_r [2];
  logic [15:0] run_r [2];
  logic [9:0] pos_r [2];
  logic [2:0] lock_r [2];
  logic [1:0] ok_r;
  logic [1:0] ev;
  logic apb_wr;
  logic apb_rd;

  assign apb_wr = psel && penable && pwrite;
  // Read data is registered in the setup cycle so it stands in the access cycle
  assign apb_rd = psel && !penable && !pwrite;
  assign pready = 1'b1;

  // Request server: each request yields exactly one answer
  assign req_ready = (state_r == sdo_sync_pkg::st_idle);

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= sdo_sync_pkg::st_idle;
      faults_r <= '0;
    end else begin
      case (state_r)
        sdo_sync_pkg::st_idle: begin
          if (req_valid) begin
            faults_r <= req_faults;
            state_r <= sdo_sync_pkg::st_eval;
          end
        end
        sdo_sync_pkg::st_eval: state_r <= sdo_sync_pkg::st_answer;
        sdo_sync_pkg::st_answer: state_r <= sdo_sync_pkg::st_idle;
        default: state_r <= sdo_sync_pkg::st_idle;
      endcase
    end
  end

  // Priority: existence, access, type, range, state, consistency, hardware
  always_comb begin
    abort_nxt = 1'b1;
    code_nxt = '{sdo_sync_pkg::ab_hi_state, sdo_sync_pkg::ab_lo_none};
    if (faults_r.no_object) begin
      code_nxt = '{sdo_sync_pkg::ab_hi_noobj, sdo_sync_pkg::ab_lo_none};
    end else if (faults_r.no_subindex) begin
      code_nxt = '{sdo_sync_pkg::ab_hi_sub, sdo_sync_pkg::ab_lo_nosub};
    end else if (faults_r.bad_access) begin
      code_nxt = '{sdo_sync_pkg::ab_hi_access, sdo_sync_pkg::ab_lo_none};
    end else if (faults_r.too_long) begin
      code_nxt = '{sdo_sync_pkg::ab_hi_type, sdo_sync_pkg::ab_lo_long};
    end else if (faults_r.too_short) begin
      code_nxt = '{sdo_sync_pkg::ab_hi_type, sdo_sync_pkg::ab_lo_short};
    end else if (faults_r.type_bad) begin
      code_nxt = '{sdo_sync_pkg::ab_hi_type, sdo_sync_pkg::ab_lo_type};
    end else if (faults_r.range_high) begin
      code_nxt = '{sdo_sync_pkg::ab_hi_sub, sdo_sync_pkg::ab_lo_high};
    end else if (faults_r.range_low) begin
      code_nxt = '{sdo_sync_pkg::ab_hi_sub, sdo_sync_pkg::ab_lo_low};
    end else if (faults_r.range_gen) begin
      code_nxt = '{sdo_sync_pkg::ab_hi_sub, sdo_sync_pkg::ab_lo_range};
    end else if (faults_r.nmt_bad) begin
      code_nxt = '{sdo_sync_pkg::ab_hi_state, sdo_sync_pkg::ab_lo_nmt};
    end else if (faults_r.locked_run) begin
      code_nxt = '{sdo_sync_pkg::ab_hi_state, sdo_sync_pkg::ab_lo_local};
    end else if (faults_r.invalid_op) begin
      code_nxt = '{sdo_sync_pkg::ab_hi_state, sdo_sync_pkg::ab_lo_inval};
    end else if (faults_r.incons) begin
      code_nxt = '{sdo_sync_pkg::ab_hi_incons, sdo_sync_pkg::ab_lo_incons};
    end else if (faults_r.store_fail) begin
      code_nxt = '{sdo_sync_pkg::ab_hi_hw, sdo_sync_pkg::ab_lo_hw};
    end else begin
      abort_nxt = 1'b0;
      code_nxt = '0;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      resp_valid <= 1'b0;
      resp_abort <= 1'b0;
      resp_code <= '0;
    end else begin
      resp_valid <= (state_r == sdo_sync_pkg::st_eval);
      if (state_r == sdo_sync_pkg::st_eval) begin
        resp_abort <= abort_nxt;
        resp_code <= code_nxt;
      end
    end
  end

  // Error latch; a new error wins over a reset in the same cycle
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      error_r <= 1'b0;
      ack_sig_d_r <= 1'b0;
      panel_d_r <= 1'b0;
    end else begin
      ack_sig_d_r <= ack_signal;
      panel_d_r <= panel_stop;
      if (error_set) begin
        error_r <= 1'b1;
      end else if (ctrl_word_valid && ctrl_word[sdo_sync_pkg::ctrl_ack_bit]
                   && ctrl_src_r == sdo_sync_pkg::src_statemachine) begin
        error_r <= 1'b0;
      end else if (panel_stop && !panel_d_r && (ctrl_src_r == sdo_sync_pkg::src_panel
                   || ctrl_src_r == sdo_sync_pkg::src_panel_term)) begin
        error_r <= 1'b0;
      end else if (ack_signal && !ack_sig_d_r && (ack_input_hw
                   || ctrl_src_r == sdo_sync_pkg::src_terminal
                   || ctrl_src_r == sdo_sync_pkg::src_panel_term)) begin
        error_r <= 1'b0;
      end
    end
  end
  assign error_active = error_r;

  // Configuration registers
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_src_r <= sdo_sync_pkg::src_statemachine;
      sb_mode_r <= sdo_sync_pkg::sb_mode_off;
      shift_r <= sdo_sync_pkg::shift_def_us;
    end else if (apb_wr) begin
      if (paddr[7:0] == sdo_sync_pkg::reg_ctrl) begin
        ctrl_src_r <= pwdata[1:0];
      end
      if (paddr[7:0] == sdo_sync_pkg::reg_sync_cfg) begin
        if (pwdata[3:0] <= sdo_sync_pkg::sb_mode_pdo3
            || pwdata[3:0] == sdo_sync_pkg::sb_mode_sync) begin
          sb_mode_r <= pwdata[3:0];
        end
        if (pwdata[25:16] < sdo_sync_pkg::shift_min_us) begin
          shift_r <= sdo_sync_pkg::shift_min_us;
        end else if (pwdata[25:16] > sdo_sync_pkg::shift_max_us) begin
          shift_r <= sdo_sync_pkg::shift_max_us;
        end else begin
          shift_r <= pwdata[25:16];
        end
      end
    end
  end

  // Microsecond divider and 1 ms periodic task counter
  assign us_tick = (us_div_r == 5'(sdo_sync_pkg::us_cycles - 1));
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      us_div_r <= '0;
      task_us_r <= '0;
    end else begin
      us_div_r <= us_tick ? 5'h00 : us_div_r + 5'h01;
      if (us_tick) begin
        task_us_r <= (task_us_r == 10'(sdo_sync_pkg::task_period_us - 1)) ? 10'h000
                     : task_us_r + 10'h001;
      end
    end
  end
  assign task_tick = us_tick && (task_us_r == 10'(sdo_sync_pkg::task_period_us - 1));

  // Sync position relative to the shifted sync point
  assign sync_us = (task_us_r >= shift_r) ? task_us_r - shift_r
                   : task_us_r + 10'(sdo_sync_pkg::task_period_us) - shift_r;

  // Mode selects which system-bus event synchronizes
  always_comb begin
    case (sb_mode_r)
      sdo_sync_pkg::sb_mode_pdo1, sdo_sync_pkg::sb_mode_pdo2,
      sdo_sync_pkg::sb_mode_pdo3: sb_event = sb_pdo_tick;
      sdo_sync_pkg::sb_mode_sync: sb_event = sb_sync_tick;
      default: sb_event = 1'b0;
    endcase
  end
  assign ev = {co_sync_tick, sb_event};

  // Per source: interval, position and lock detection
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_src
      always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
          run_r[g] <= sdo_sync_pkg::period_reset;
          period_r[g] <= sdo_sync_pkg::period_reset;
          pos_r[g] <= '0;
          lock_r[g] <= '0;
          ok_r[g] <= 1'b0;
        end else begin
          if (ev[g]) begin
            run_r[g] <= '0;
            // A microsecond tick in the event cycle still belongs to the closing interval
            period_r[g] <= (us_tick && run_r[g] != 16'hffff) ? run_r[g] + 16'h0001
                           : run_r[g];
            pos_r[g] <= sync_us;
            // Lock needs several events at a near-constant task position
            if ((sync_us >= pos_r[g] ? sync_us - pos_r[g] : pos_r[g] - sync_us)
                <= sdo_sync_pkg::lock_tol_us) begin
              if (lock_r[g] != sdo_sync_pkg::lock_count) begin
                lock_r[g] <= lock_r[g] + 3'h1;
              end
            end else begin
              lock_r[g] <= '0;
            end
          end else if (us_tick && run_r[g] != 16'hffff) begin
            run_r[g] <= run_r[g] + 16'h0001;
          end
          // Lock drops if events stop for two task periods
          ok_r[g] <= (lock_r[g] == sdo_sync_pkg::lock_count)
                     && (run_r[g] < 16'(2 * sdo_sync_pkg::task_period_us))
                     && !(g == 0 && sb_mode_r == sdo_sync_pkg::sb_mode_off);
        end
      end
    end
  endgenerate
  assign sb_sync_ok = ok_r[0];
  assign co_sync_ok = ok_r[1];

  // APB read mux
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      prdata <= '0;
    end else if (apb_rd) begin
      case (paddr[7:0])
        sdo_sync_pkg::reg_req: prdata <= {31'h0, req_ready};
        sdo_sync_pkg::reg_abort: prdata <= resp_code;
        sdo_sync_pkg::reg_ctrl: prdata <= {30'h0, ctrl_src_r};
        sdo_sync_pkg::reg_err: prdata <= {31'h0, error_r};
        sdo_sync_pkg::reg_sync_cfg: prdata <= {6'h0, shift_r, 12'h0, sb_mode_r};
        sdo_sync_pkg::reg_sync_stat: prdata <= {30'h0, ok_r[1], ok_r[0]};
        sdo_sync_pkg::reg_sb_period: prdata <= {16'h0, period_r[0]};
        sdo_sync_pkg::reg_sb_pos: prdata <= {22'h0, pos_r[0]};
        sdo_sync_pkg::reg_co_period: prdata <= {16'h0, period_r[1]};
        sdo_sync_pkg::reg_co_pos: prdata <= {22'h0, pos_r[1]};
        default: prdata <= '0;
      endcase
    end
  end

  // Unmapped addresses answer with an error in the access phase
  always_comb begin
    pslverr = 1'b0;
    if (psel && penable && (paddr[1:0] != 2'b00 || paddr[7:0] > sdo_sync_pkg::reg_co_pos
        || paddr[31:8] != 24'h0)) begin
      pslverr = 1'b1;
    end
  end
endmodule

// ===== rtl/sdo_sync_pkg.sv
// Shared constants and types for the parameter-access abort and sync-status block
package sdo_sync_pkg;
  // Abort codes, high and low halves
  localparam logic [15:0] ab_hi_access = 16'h0601;
  localparam logic [15:0] ab_hi_noobj = 16'h0602;
  localparam logic [15:0] ab_hi_incons = 16'h0604;
  localparam logic [15:0] ab_hi_hw = 16'h0606;
  localparam logic [15:0] ab_hi_type = 16'h0607;
  localparam logic [15:0] ab_hi_sub = 16'h0609;
  localparam logic [15:0] ab_hi_state = 16'h0800;
  localparam logic [15:0] ab_lo_none = 16'h0000;
  localparam logic [15:0] ab_lo_incons = 16'h0047;
  localparam logic [15:0] ab_lo_type = 16'h0010;
  localparam logic [15:0] ab_lo_long = 16'h0012;
  localparam logic [15:0] ab_lo_short = 16'h0013;
  localparam logic [15:0] ab_lo_nosub = 16'h0011;
  localparam logic [15:0] ab_lo_range = 16'h0030;
  localparam logic [15:0] ab_lo_high = 16'h0031;
  localparam logic [15:0] ab_lo_low = 16'h0032;
  localparam logic [15:0] ab_lo_inval = 16'h0020;
  localparam logic [15:0] ab_lo_local = 16'h0021;
  // Low codes not given for storage and NMT faults
  localparam logic [15:0] ab_lo_hw = 16'h0000;
  localparam logic [15:0] ab_lo_nmt = 16'h0000;

  // APB register byte addresses
  localparam logic [7:0] reg_req = 8'h00;
  localparam logic [7:0] reg_abort = 8'h04;
  localparam logic [7:0] reg_ctrl = 8'h08;
  localparam logic [7:0] reg_err = 8'h0c;
  localparam logic [7:0] reg_sync_cfg = 8'h10;
  localparam logic [7:0] reg_sync_stat = 8'h14;
  localparam logic [7:0] reg_sb_period = 8'h18;
  localparam logic [7:0] reg_sb_pos = 8'h1c;
  localparam logic [7:0] reg_co_period = 8'h20;
  localparam logic [7:0] reg_co_pos = 8'h24;

  // Control word acknowledge bit
  localparam int ctrl_ack_bit = 7;
  localparam logic [15:0] ctrl_ack_val = 16'h0080;

  // Control source selection
  localparam logic [1:0] src_statemachine = 2'h0;
  localparam logic [1:0] src_panel = 2'h1;
  localparam logic [1:0] src_terminal = 2'h2;
  localparam logic [1:0] src_panel_term = 2'h3;

  // System-bus sync modes
  localparam logic [3:0] sb_mode_off = 4'h0;
  localparam logic [3:0] sb_mode_pdo1 = 4'h1;
  localparam logic [3:0] sb_mode_pdo2 = 4'h2;
  localparam logic [3:0] sb_mode_pdo3 = 4'h3;
  localparam logic [3:0] sb_mode_sync = 4'ha;
  localparam logic [10:0] sync_id_default = 11'h080;

  // Timing
  localparam int clk_mhz = 25;
  localparam int us_cycles = clk_mhz;
  localparam int task_period_us = 1000;
  localparam logic [9:0] shift_min_us = 10'd700;
  localparam logic [9:0] shift_max_us = 10'd900;
  localparam logic [9:0] shift_def_us = 10'd800;
  localparam logic [9:0] lock_tol_us = 10'h014;
  localparam logic [2:0] lock_count = 3'h4;
  localparam logic [15:0] period_reset = 16'h0000;

  // One parameter request with its fault causes
  typedef struct packed {
    logic no_object;
    logic bad_access;
    logic no_subindex;
    logic incons;
    logic type_bad;
    logic too_long;
    logic too_short;
    logic range_gen;
    logic range_high;
    logic range_low;
    logic invalid_op;
    logic locked_run;
    logic nmt_bad;
    logic store_fail;
  } req_faults_type;

  typedef struct packed {
    logic [15:0] hi;
    logic [15:0] lo;
  } abort_code_type;

  typedef enum logic [2:0] {
    st_idle = 3'b001,
    st_eval = 3'b010,
    st_answer = 3'b100
  } srv_state_type;
endpackage

// ===== sim/sdo_sync_chk.sv
// Concurrent checks on the abort coder, the error flag and the task tick
`timescale 1ns/1ps
module sdo_sync_chk (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic req_valid,
  input wire sdo_sync_pkg::req_faults_type req_faults,
  input wire logic req_ready,
  input wire logic resp_valid,
  input wire logic resp_abort,
  input wire sdo_sync_pkg::abort_code_type resp_code,
  input wire logic error_set,
  input wire logic error_active,
  input wire logic task_tick
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  logic take;
  logic [15:0] tick_cnt_r;
  logic tick_seen_r;
  assign take = req_valid && req_ready;
  // First tick after reset has no reference, so it is not judged
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tick_cnt_r <= 16'h0000;
      tick_seen_r <= 1'h0;
    end else if (task_tick) begin
      tick_cnt_r <= 16'h0000;
      tick_seen_r <= 1'h1;
    end else begin
      tick_cnt_r <= tick_cnt_r + 16'h0001;
    end
  end
  answer_delay_a: assert property (take |-> ##2 resp_valid)
    else $error("answer not two cycles after request");
  ready_gap_a: assert property (take |=> !req_ready [*2] ##1 req_ready)
    else $error("request window wrong after take");
  single_pulse_a: assert property (resp_valid |=> !resp_valid)
    else $error("answer longer than one cycle");
  code_hold_a: assert property (!resp_valid |-> $stable(resp_code))
    else $error("abort code changed without answer");
  no_object_a: assert property (take && req_faults.no_object |->
    ##2 resp_abort && resp_code == {16'h0602, 16'h0000})
    else $error("missing parameter not answered first");
  access_a: assert property (take && req_faults[13:11] == 3'h2 |->
    ##2 resp_abort && resp_code.hi == 16'h0601)
    else $error("access fault code wrong");
  confirm_a: assert property (take && req_faults == '0 |-> ##2 !resp_abort)
    else $error("clean request aborted");
  error_set_a: assert property (error_set |=> error_active)
    else $error("error not raised");
  apb_answer_a: assert property (pready && (!pslverr || (psel && penable)))
    else $error("bus answer out of phase");
  task_period_a: assert property (task_tick && tick_seen_r |-> tick_cnt_r == 16'h61a7)
    else $error("task tick not one millisecond apart");
endmodule

// ===== sim/sync_master.sv
// Bus master model issuing periodic sync events
`timescale 1ns/1ps
module sync_master #(
  parameter int period = 25000
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic run,
  input wire logic use_sync,
  output logic sb_sync_tick,
  output logic sb_pdo_tick,
  output logic co_sync_tick
);
  int cnt_r;
  logic fire;
  assign fire = run && (cnt_r == period - 1);
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_r <= 0;
    end else if (!run || fire) begin
      cnt_r <= 0;
    end else begin
      cnt_r <= cnt_r + 1;
    end
  end
  // One schedule feeds both buses so their periods match exactly
  assign sb_pdo_tick = fire && !use_sync;
  assign sb_sync_tick = fire && use_sync;
  assign co_sync_tick = fire;
endmodule

// ===== sim/tb_top.sv
// Self-checking bench for the abort coder, error reset and sync status
`timescale 1ns/1ps
module tb_top;
  logic ref_clk = 1'h0;
  logic sys_rst = 1'h1;
  logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata;
  logic pready, pslverr, req_ready, resp_valid, resp_abort, error_active;
  logic req_valid = 1'h0;
  sdo_sync_pkg::req_faults_type req_faults = '0;
  sdo_sync_pkg::abort_code_type resp_code;
  logic ctrl_word_valid = 1'h0;
  logic [15:0] ctrl_word = 16'h0000;
  logic panel_stop = 1'h0, ack_signal = 1'h0, ack_input_hw = 1'h0, error_set = 1'h0;
  logic sb_sync_tick, sb_pdo_tick, co_sync_tick, task_tick, sb_sync_ok, co_sync_ok;
  logic run = 1'h0, use_sync = 1'h0;
  int error_cnt = 0;
  int num_checks = 0;
  logic [31:0] rd_q;
  logic rd_e;
  // Faults beside the abort word they must give; last rows test priority
  logic [45:0] rows [19] = '{
    {14'h2000, 32'h0602_0000}, {14'h1000, 32'h0601_0000}, {14'h0800, 32'h0609_0011},
    {14'h0400, 32'h0604_0047}, {14'h0200, 32'h0607_0010}, {14'h0100, 32'h0607_0012},
    {14'h0080, 32'h0607_0013}, {14'h0040, 32'h0609_0030}, {14'h0020, 32'h0609_0031},
    {14'h0010, 32'h0609_0032}, {14'h0008, 32'h0800_0020}, {14'h0004, 32'h0800_0021},
    {14'h0002, 32'h0800_0000}, {14'h0001, 32'h0606_0000}, {14'h0000, 32'h0000_0000},
    {14'h3fff, 32'h0602_0000}, {14'h1020, 32'h0601_0000}, {14'h0280, 32'h0607_0013},
    {14'h0041, 32'h0609_0030}};
  always #20 ref_clk = ~ref_clk;
  sdo_sync_ctrl i_sdo_sync_ctrl (.ref_clk, .sys_rst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .req_valid, .req_faults, .req_ready, .resp_valid,
    .resp_abort, .resp_code, .ctrl_word_valid, .ctrl_word, .panel_stop, .ack_signal,
    .ack_input_hw, .error_set, .error_active, .sb_sync_tick, .sb_pdo_tick, .co_sync_tick,
    .task_tick, .sb_sync_ok, .co_sync_ok);
  sync_master #(.period(25000)) i_sync_master (.ref_clk, .sys_rst, .run, .use_sync,
    .sb_sync_tick, .sb_pdo_tick, .co_sync_tick);
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= {24'h0, a};
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'h1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    rd_q = prdata;
    rd_e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  // Read data is taken at the access edge
  task automatic rd(input logic [7:0] a);
    apb(1'h0, a, 32'h0);
  endtask
  task automatic req(input logic [13:0] f, input logic [31:0] exp);
    int n;
    n = 0;
    @(posedge ref_clk);
    req_valid <= 1'h1;
    req_faults <= f;
    do begin
      @(posedge ref_clk);
      n++;
    end while (req_ready !== 1'h1 && n < 10);
    req_valid <= 1'h0;
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (resp_valid !== 1'h1 && n < 5);
    check("resp_code", resp_code, exp);
    check("resp_abort", {31'h0, resp_abort}, {31'h0, exp != 32'h0});
  endtask
  task automatic err_try(input int m, input logic exp);
    @(posedge ref_clk);
    error_set <= 1'h1;
    @(posedge ref_clk);
    error_set <= 1'h0;
    ctrl_word_valid <= (m == 0);
    ctrl_word <= 16'h0080;
    panel_stop <= (m == 1);
    ack_signal <= (m == 2);
    @(posedge ref_clk);
    ctrl_word_valid <= 1'h0;
    repeat (2) @(negedge ref_clk);
    check("error_active", {31'h0, error_active}, {31'h0, exp});
    @(posedge ref_clk);
    panel_stop <= 1'h0;
    ack_signal <= 1'h0;
  endtask
  initial begin
    int n;
    repeat (4) @(posedge ref_clk);
    sys_rst <= 1'h0;
    @(negedge ref_clk);
    check("req_ready", {31'h0, req_ready}, 32'h1);
    check("error_active", {31'h0, error_active}, 32'h0);
    check("sync_ok", {30'h0, co_sync_ok, sb_sync_ok}, 32'h0);
    rd(sdo_sync_pkg::reg_sync_cfg);
    check("sync_cfg", rd_q, 32'h0320_0000);
    foreach (rows[i]) req(rows[i][45:32], rows[i][31:0]);
    rd(sdo_sync_pkg::reg_abort);
    check("abort_reg", rd_q, 32'h0609_0030);
    apb(1'h1, 8'h28, 32'hffff_ffff);
    check("pslverr", {31'h0, rd_e}, 32'h1);
    rd(8'h28);
    check("unmapped", rd_q, 32'h0);
    // Shift is clamped and an unlisted mode leaves the old one in place
    apb(1'h1, sdo_sync_pkg::reg_sync_cfg, 32'h03b6_0005);
    rd(sdo_sync_pkg::reg_sync_cfg);
    check("sync_cfg", rd_q, 32'h0384_0000);
    apb(1'h1, sdo_sync_pkg::reg_sync_cfg, 32'h0258_000a);
    rd(sdo_sync_pkg::reg_sync_cfg);
    check("sync_cfg", rd_q, 32'h02bc_000a);
    for (int s = 0; s < 4; s++) begin
      apb(1'h1, sdo_sync_pkg::reg_ctrl, {30'h0, 2'(s)});
      for (int m = 0; m < 3; m++) begin
        err_try(m, !((m == 0 && s == 0) || (m == 1 && s % 2 == 1) || (m == 2 && s >= 2)));
      end
    end
    apb(1'h1, sdo_sync_pkg::reg_ctrl, 32'h0);
    ack_input_hw <= 1'h1;
    err_try(2, 1'h0);
    apb(1'h1, sdo_sync_pkg::reg_sync_cfg, 32'h0320_0001);
    @(posedge ref_clk);
    run <= 1'h1;
    n = 0;
    while (!(sb_sync_ok === 1'h1 && co_sync_ok === 1'h1) && n < 160000) begin
      @(negedge ref_clk);
      n++;
    end
    check("sync_ok", {30'h0, co_sync_ok, sb_sync_ok}, 32'h3);
    rd(sdo_sync_pkg::reg_sb_period);
    check("sb_period", rd_q, 32'h3e8);
    rd(sdo_sync_pkg::reg_co_period);
    check("co_period", rd_q, 32'h3e8);
    rd(sdo_sync_pkg::reg_sync_stat);
    check("sync_stat", rd_q, 32'h3);
    apb(1'h1, sdo_sync_pkg::reg_sync_cfg, 32'h0320_0000);
    repeat (2) @(negedge ref_clk);
    check("sb_sync_ok", {31'h0, sb_sync_ok}, 32'h0);
    end_of_test();
  end
  initial begin
    repeat (300000) @(posedge ref_clk);
    error_cnt++;
    end_of_test();
  end
endmodule
bind sdo_sync_ctrl sdo_sync_chk i_sdo_sync_chk (.ref_clk, .sys_rst, .psel, .penable, .pready,
  .pslverr, .req_valid, .req_faults, .req_ready, .resp_valid, .resp_abort, .resp_code,
  .error_set, .error_active, .task_tick);
